//--- rsc_top.v
// return stack and reset cause flags behind an axi4-lite slave
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "rsc_map.vh"

module rsc_top #(
    parameter PCW = 21,
    parameter AW = 8
) (
    // clock and reset
    input wire mclk,
    input wire rst_b,
    // axi4-lite write address and data
    input wire awvalid,
    output reg awready,
    input wire [AW-1:0] awaddr,
    input wire wvalid,
    output reg wready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    // axi4-lite write response
    output reg bvalid,
    input wire bready,
    output reg [1:0] bresp,
    // axi4-lite read
    input wire arvalid,
    output reg arready,
    input wire [AW-1:0] araddr,
    output reg rvalid,
    input wire rready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    // core call and return
    input wire pushReq,
    input wire [PCW-1:0] pushData,
    input wire popReq,
    input wire [PCW-1:0] pcNow,
    output reg [PCW-1:0] popData,
    output reg popValid,
    // reset sequencer events
    input wire evtResetInstr,
    input wire evtBrownout,
    input wire evtExtClear,
    input wire evtWatchdog,
    input wire evtIntWake,
    input wire wakeHighPri,
    input wire [1:0] pwrMode,
    // configuration
    input wire overflowResetEnable,
    input wire [1:0] brownoutConfigField,
    input wire highPriorityGlobalEnable,
    input wire lowPriorityGlobalEnable,
    // program counter redirect and reset request to the core
    output reg pcLoad,
    output reg [PCW-1:0] pcLoadAddr,
    output reg stackResetReq
);

    // ==========================================================================
    // address decode shared by read and write paths
    function [2:0] regIdx;
        input [AW-1:0] addr;
        begin
            case (addr)
                `RSC_OFS_STACK_PTR: regIdx = `RSC_IDX_STACK_PTR;
                `RSC_OFS_TOS_LOW: regIdx = `RSC_IDX_TOS_LOW;
                `RSC_OFS_TOS_HIGH: regIdx = `RSC_IDX_TOS_HIGH;
                `RSC_OFS_TOS_UPPER: regIdx = `RSC_IDX_TOS_UPPER;
                `RSC_OFS_RESET_CAUSE: regIdx = `RSC_IDX_RESET_CAUSE;
                default: regIdx = `RSC_IDX_NONE;
            endcase
        end
    endfunction

    // ==========================================================================
    // state
    reg [4:0] sp_r;
    reg full_r;
    reg unf_r;
    reg sbor_r;
    reg ri_r;
    reg to_r;
    reg pd_r;
    reg por_r;
    reg bor_r;
    reg awHeld_r;
    reg wHeld_r;
    reg [AW-1:0] awAddr_r;
    reg [7:0] wByte_r;
    reg wLane_r;

    reg [4:0] sp_nxt;
    reg full_nxt;
    reg unf_nxt;
    reg sbor_nxt;
    reg ri_nxt;
    reg to_nxt;
    reg pd_nxt;
    reg por_nxt;
    reg bor_nxt;
    reg [PCW-1:0] popData_nxt;
    reg popValid_nxt;
    reg pcLoad_nxt;
    reg [PCW-1:0] pcLoadAddr_nxt;
    reg stackResetReq_nxt;
    reg memWe;
    reg [4:0] memWa;
    reg [PCW-1:0] memWd;
    reg [7:0] rdByte;
    reg anyReset;

    wire [PCW-1:0] memRd;
    wire cfgSoft;
    wire lowPower;
    wire [PCW-1:0] pcResume;
    wire awTake;
    wire wTake;
    wire arTake;
    wire wrDo;
    wire [2:0] wrIdx;
    wire [2:0] rdIdx;
    wire awHeld_nxt;
    wire wHeld_nxt;
    wire bvalid_nxt;
    wire rvalid_nxt;

    // ==========================================================================
    // stack storage, read at the current pointer; a push writes one above it
    rsc_stack_mem #(
        .WIDTH(PCW),
        .ABITS(5)
    ) uStackMem (
        .mclk(mclk),
        .wrEn(memWe),
        .wrAddr(memWa),
        .wrData(memWd),
        .rdAddr(sp_r),
        .rdData(memRd)
    );

    // soft brown-out enable only exists with the matching config value
    assign cfgSoft = (brownoutConfigField == `RSC_BOR_CFG_SOFT);
    assign lowPower = (pwrMode == `RSC_MODE_IDLE) || (pwrMode == `RSC_MODE_SLEEP);
    assign pcResume = pcNow + `RSC_PC_STEP;

    // ==========================================================================
    // bus handshakes: one write and one read in flight at most
    assign awTake = awvalid & awready;
    assign wTake = wvalid & wready;
    assign arTake = arvalid & arready;
    // write happens the cycle after both halves are held, so either order works
    assign wrDo = awHeld_r & wHeld_r;
    assign wrIdx = regIdx(awAddr_r);
    assign rdIdx = regIdx(araddr);
    assign awHeld_nxt = wrDo ? 1'b0 : (awHeld_r | awTake);
    assign wHeld_nxt = wrDo ? 1'b0 : (wHeld_r | wTake);
    assign bvalid_nxt = wrDo ? 1'b1 : (bvalid & ~bready);
    assign rvalid_nxt = arTake ? 1'b1 : (rvalid & ~rready);

    // ==========================================================================
    // read data mux, reserved bits read as zero
    always @* begin
        rdByte = 8'h00;
        case (rdIdx)
            `RSC_IDX_STACK_PTR: begin
                rdByte = {full_r, unf_r, 1'b0, sp_r};
            end
            `RSC_IDX_TOS_LOW: begin
                rdByte = memRd[7:0];
            end
            `RSC_IDX_TOS_HIGH: begin
                rdByte = memRd[15:8];
            end
            `RSC_IDX_TOS_UPPER: begin
                rdByte = {{(24-PCW){1'b0}}, memRd[PCW-1:16]};
            end
            `RSC_IDX_RESET_CAUSE: begin
                rdByte = {1'b0, sbor_r & cfgSoft, 1'b0, ri_r, to_r, pd_r, por_r, bor_r};
            end
            default: begin
                rdByte = 8'h00;
            end
        endcase
    end

    // ==========================================================================
    // next state: software writes first, core stack ops next, reset events last
    // so a hardware set always beats a software clear in the same cycle
    always @* begin
        sp_nxt = sp_r;
        full_nxt = full_r;
        unf_nxt = unf_r;
        sbor_nxt = sbor_r;
        ri_nxt = ri_r;
        to_nxt = to_r;
        pd_nxt = pd_r;
        por_nxt = por_r;
        bor_nxt = bor_r;
        popData_nxt = popData;
        popValid_nxt = 1'b0;
        pcLoad_nxt = 1'b0;
        pcLoadAddr_nxt = pcLoadAddr;
        stackResetReq_nxt = 1'b0;
        memWe = 1'b0;
        memWa = sp_r;
        memWd = memRd;
        anyReset = 1'b0;

        // software writes, low byte lane only
        if (wrDo && wLane_r) begin
            case (wrIdx)
                `RSC_IDX_STACK_PTR: begin
                    sp_nxt = wByte_r[4:0];
                    // flags are clear-only from software
                    if (!wByte_r[`RSC_SP_FULL_BIT]) full_nxt = 1'b0;
                    if (!wByte_r[`RSC_SP_UNF_BIT]) unf_nxt = 1'b0;
                end
                `RSC_IDX_TOS_LOW: begin
                    memWe = 1'b1;
                    memWd = {memRd[PCW-1:8], wByte_r};
                end
                `RSC_IDX_TOS_HIGH: begin
                    memWe = 1'b1;
                    memWd = {memRd[PCW-1:16], wByte_r, memRd[7:0]};
                end
                `RSC_IDX_TOS_UPPER: begin
                    memWe = 1'b1;
                    memWd = {wByte_r[PCW-17:0], memRd[15:0]};
                end
                `RSC_IDX_RESET_CAUSE: begin
                    sbor_nxt = wByte_r[`RSC_RC_SBOR_BIT] & cfgSoft;
                    por_nxt = wByte_r[`RSC_RC_POR_BIT];
                    bor_nxt = wByte_r[`RSC_RC_BOR_BIT];
                end
                default: begin
                    memWe = 1'b0;
                end
            endcase
        end

        // push wins over a same-cycle pop
        if (pushReq) begin
            if (sp_r == `RSC_SP_MAX) begin
                // already full: entry 31 is never overwritten
                full_nxt = 1'b1;
                if (overflowResetEnable) begin
                    sp_nxt = `RSC_SP_ZERO;
                    stackResetReq_nxt = 1'b1;
                    anyReset = 1'b1;
                end
            end else begin
                // increment first, then write at the new top
                sp_nxt = sp_r + 5'h01;
                memWe = 1'b1;
                memWa = sp_r + 5'h01;
                memWd = pushData;
                if (sp_r == `RSC_SP_MAX - 5'h01) begin
                    full_nxt = 1'b1;
                    if (overflowResetEnable) begin
                        // store, then reset
                        sp_nxt = `RSC_SP_ZERO;
                        stackResetReq_nxt = 1'b1;
                        anyReset = 1'b1;
                    end
                end
            end
        end else if (popReq) begin
            popValid_nxt = 1'b1;
            if (sp_r == `RSC_SP_ZERO) begin
                // zero sends the core to address zero
                popData_nxt = `RSC_VEC_RESET;
                unf_nxt = 1'b1;
            end else begin
                // read first, then decrement
                popData_nxt = memRd;
                sp_nxt = sp_r - 5'h01;
            end
        end

        // sequencer events, one at a time by priority
        if (evtBrownout) begin
            anyReset = 1'b1;
            ri_nxt = 1'b1;
            to_nxt = 1'b1;
            pd_nxt = 1'b1;
            bor_nxt = 1'b0;
        end else if (evtExtClear) begin
            anyReset = 1'b1;
            case (pwrMode)
                `RSC_MODE_RUN: begin
                    to_nxt = 1'b1;
                end
                `RSC_MODE_IDLE, `RSC_MODE_SLEEP: begin
                    to_nxt = 1'b1;
                    pd_nxt = 1'b0;
                end
                default: begin
                    to_nxt = to_r;
                end
            endcase
        end else if (evtWatchdog) begin
            to_nxt = 1'b0;
            if (lowPower) begin
                // a wake, not a reset
                pd_nxt = 1'b0;
                pcLoad_nxt = 1'b1;
                pcLoadAddr_nxt = pcResume;
            end else begin
                anyReset = 1'b1;
            end
        end else if (evtResetInstr) begin
            anyReset = 1'b1;
            ri_nxt = 1'b0;
        end else if (evtIntWake) begin
            pd_nxt = 1'b0;
            pcLoad_nxt = 1'b1;
            if (wakeHighPri && highPriorityGlobalEnable) begin
                pcLoadAddr_nxt = `RSC_VEC_HIGH;
            end else if (!wakeHighPri && lowPriorityGlobalEnable) begin
                pcLoadAddr_nxt = `RSC_VEC_LOW;
            end else begin
                pcLoadAddr_nxt = pcResume;
            end
        end

        // common reset effects; stack flags are left alone
        if (anyReset) begin
            sp_nxt = `RSC_SP_ZERO;
            pcLoad_nxt = 1'b1;
            pcLoadAddr_nxt = `RSC_VEC_RESET;
            popValid_nxt = 1'b0;
            if (!cfgSoft) sbor_nxt = 1'b0;
        end
    end

    // ==========================================================================
    // registers; power-on is the async reset
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sp_r <= `RSC_SP_ZERO;
            full_r <= `RSC_POR_STK;
            unf_r <= `RSC_POR_STK;
            sbor_r <= `RSC_POR_SBOR;
            ri_r <= `RSC_POR_RI;
            to_r <= `RSC_POR_TO;
            pd_r <= `RSC_POR_PD;
            por_r <= `RSC_POR_POR;
            bor_r <= `RSC_POR_BOR;
            popData <= `RSC_VEC_RESET;
            popValid <= 1'b0;
            pcLoad <= 1'b0;
            pcLoadAddr <= `RSC_VEC_RESET;
            stackResetReq <= 1'b0;
        end else begin
            sp_r <= sp_nxt;
            full_r <= full_nxt;
            unf_r <= unf_nxt;
            sbor_r <= sbor_nxt;
            ri_r <= ri_nxt;
            to_r <= to_nxt;
            pd_r <= pd_nxt;
            por_r <= por_nxt;
            bor_r <= bor_nxt;
            popData <= popData_nxt;
            popValid <= popValid_nxt;
            pcLoad <= pcLoad_nxt;
            pcLoadAddr <= pcLoadAddr_nxt;
            stackResetReq <= stackResetReq_nxt;
        end
    end

    // ==========================================================================
    // axi4-lite write channel; ready drops while a half is held
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            awAddr_r <= {AW{1'b0}};
            wByte_r <= 8'h00;
            wLane_r <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `RSC_RESP_OKAY;
        end else begin
            awHeld_r <= awHeld_nxt;
            wHeld_r <= wHeld_nxt;
            if (awTake) awAddr_r <= awaddr;
            if (wTake) begin
                wByte_r <= wdata[7:0];
                wLane_r <= wstrb[0];
            end
            // no new write until the response is taken
            awready <= ~awHeld_nxt & ~bvalid_nxt;
            wready <= ~wHeld_nxt & ~bvalid_nxt;
            bvalid <= bvalid_nxt;
            if (wrDo) begin
                bresp <= (wrIdx == `RSC_IDX_NONE) ? `RSC_RESP_SLVERR : `RSC_RESP_OKAY;
            end
        end
    end

    // ==========================================================================
    // axi4-lite read channel; data is sampled at the address edge
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `RSC_RESP_OKAY;
        end else begin
            arready <= ~rvalid_nxt;
            rvalid <= rvalid_nxt;
            if (arTake) begin
                rdata <= {24'h000000, rdByte};
                rresp <= (rdIdx == `RSC_IDX_NONE) ? `RSC_RESP_SLVERR : `RSC_RESP_OKAY;
            end
        end
    end

endmodule // rsc_top

`default_nettype wire

//--- rsc_map.vh
// register map and constants of the return stack and reset cause block
// ==========================================================================
// Functional notes
// - pointer holds 0 to 31 in five low bits
// - push: increment, write; pop: read, decrement
// - any reset zeroes the pointer
// - software reads and writes the pointer
// - 31 pushes without pop set full
// - overflow reset on: 31st push stores, sets full, resets
// - overflow reset off: 31st push sets full, pointer stays 31
// - pop when empty gives zero, sets underflow
// - full, underflow (bits 7, 6) clear by software or power-on
// - underflow goes to zero, not a reset
// - push writes current pc at the new top
// - pop decrements, previous entry becomes top
// - software reads and writes top entry bytes
// - external clear in run: zero, time-out set
// - external clear asleep: zero, time-out set, power-down clear
// - external clear at full power: zero, flags kept
// - watchdog awake: reset to zero, time-out clear
// - watchdog asleep: pc plus two, time-out and power-down clear
// - interrupt wake: power-down clear, pc plus two or vector
// - soft brown-out enable: one at power-on, kept only with config 01
// - watchdog wake keeps registers
`ifndef RSC_MAP_VH
`define RSC_MAP_VH

// ==========================================================================
// register byte offsets
`define RSC_OFS_STACK_PTR 8'h00
`define RSC_OFS_TOS_LOW 8'h04
`define RSC_OFS_TOS_HIGH 8'h08
`define RSC_OFS_TOS_UPPER 8'h0C
`define RSC_OFS_RESET_CAUSE 8'h10

// internal register indices, unmapped last
`define RSC_IDX_STACK_PTR 3'h0
`define RSC_IDX_TOS_LOW 3'h1
`define RSC_IDX_TOS_HIGH 3'h2
`define RSC_IDX_TOS_UPPER 3'h3
`define RSC_IDX_RESET_CAUSE 3'h4
`define RSC_IDX_NONE 3'h7

// ==========================================================================
// stack pointer register fields
`define RSC_SP_FULL_BIT 7
`define RSC_SP_UNF_BIT 6
`define RSC_SP_MAX 5'h1F
`define RSC_SP_ZERO 5'h00

// reset cause register fields
`define RSC_RC_SBOR_BIT 6
`define RSC_RC_RI_BIT 4
`define RSC_RC_TO_BIT 3
`define RSC_RC_PD_BIT 2
`define RSC_RC_POR_BIT 1
`define RSC_RC_BOR_BIT 0

// power-on values of flags
`define RSC_POR_SBOR 1'b1
`define RSC_POR_RI 1'b1
`define RSC_POR_TO 1'b1
`define RSC_POR_PD 1'b1
`define RSC_POR_POR 1'b0
`define RSC_POR_BOR 1'b0
`define RSC_POR_STK 1'b0

// ==========================================================================
// brown-out config value enabling software control, power modes
`define RSC_BOR_CFG_SOFT 2'h1
`define RSC_MODE_FULL 2'h0
`define RSC_MODE_RUN 2'h1
`define RSC_MODE_IDLE 2'h2
`define RSC_MODE_SLEEP 2'h3

// program counter targets
`define RSC_VEC_RESET 21'h000000
`define RSC_VEC_HIGH 21'h000008
`define RSC_VEC_LOW 21'h000018
`define RSC_PC_STEP 21'h000002

// bus responses
`define RSC_RESP_OKAY 2'h0
`define RSC_RESP_SLVERR 2'h2

`endif

//--- rsc_stack_mem.v
// return address storage array with one write port and one asynchronous read port
`timescale 1ns/1ns
`default_nettype none

module rsc_stack_mem #(
    parameter WIDTH = 21,
    parameter ABITS = 5
) (
    // clock
    input wire mclk,
    // write port
    input wire wrEn,
    input wire [ABITS-1:0] wrAddr,
    input wire [WIDTH-1:0] wrData,
    // read port
    input wire [ABITS-1:0] rdAddr,
    output wire [WIDTH-1:0] rdData
);

    // entry 0 is only seen when the stack is empty
    reg [WIDTH-1:0] mem [0:(1<<ABITS)-1];

    // ==========================================================================
    // write on the clock, no reset: contents are data, not control
    always @(posedge mclk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    // combinational read: pop sees the entry at once
    assign rdData = mem[rdAddr];

endmodule // rsc_stack_mem

`default_nettype wire

//--- rsc_top_monitor.sv
// port checks of the return stack and reset cause block
`timescale 1ns/1ns
`default_nettype none
module rsc_top_monitor #(parameter PCW = 21) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // register bus handshakes
    input wire logic arready, rvalid, rready, bvalid, bready,
    input wire logic [1:0] bresp,
    input wire logic [31:0] rdata,
    // stack traffic and events
    input wire logic pushReq, popReq, popValid, pcLoad, stackResetReq,
    input wire logic evtBrownout, evtExtClear, evtWatchdog, evtResetInstr,
    input wire logic [1:0] pwrMode,
    input wire logic [PCW-1:0] pcNow, pcLoadAddr
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // events that may override a same-cycle pop
    wire anyRst = evtBrownout | evtExtClear | evtWatchdog | evtResetInstr;
    AST_POP_ANSWER: assert property (popReq && !pushReq && !anyRst |=> popValid)
        else $error("pop not answered");
    AST_POP_QUIET: assert property (!popReq |=> !popValid)
        else $error("pop answer without pop");
    AST_OVF_TARGET: assert property (stackResetReq |-> pcLoad && pcLoadAddr == 0)
        else $error("overflow target wrong");
    AST_OVF_CAUSE: assert property (stackResetReq |-> $past(pushReq))
        else $error("reset without push");
    AST_EXT_CLEAR: assert property (evtExtClear && !evtBrownout |=> pcLoad && pcLoadAddr == 0)
        else $error("ext clear target wrong");
    AST_WD_WAKE: assert property (evtWatchdog && pwrMode[1] && !evtBrownout && !evtExtClear
        |=> pcLoad && pcLoadAddr == $past(pcNow) + 21'h000002)
        else $error("watchdog wake target wrong");
    AST_WD_RUN: assert property (evtWatchdog && !pwrMode[1] && !evtBrownout && !evtExtClear
        |=> pcLoad && pcLoadAddr == 0)
        else $error("watchdog reset target wrong");
    AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    AST_AR_BLOCK: assert property (rvalid |-> !arready)
        else $error("read accepted while answer pending");
endmodule // rsc_top_monitor
bind rsc_top rsc_top_monitor #(.PCW(PCW)) i_rsc_top_monitor(.mclk, .rst_b, .arready, .rvalid, .rready,
    .bvalid, .bready, .bresp, .rdata, .pushReq, .popReq, .popValid, .pcLoad, .stackResetReq,
    .evtBrownout, .evtExtClear, .evtWatchdog, .evtResetInstr, .pwrMode, .pcNow, .pcLoadAddr);
`default_nettype wire

//--- rsc_core_model.sv
// call and return side of the core that pushes and pops return addresses
`timescale 1ns/1ns
`default_nettype none
module rsc_core_model (
    // clock
    input wire logic mclk,
    // push and pop requests
    output logic pushReq,
    output logic [20:0] pushData,
    output logic popReq,
    // pop answer
    input wire logic popValid,
    input wire logic [20:0] popData
);
    // idle at time zero, data line junk outside a push
    initial begin
        pushReq = 1'b0;
        popReq = 1'b0;
        pushData = 21'h1FFFFF;
    end
    // one-cycle push pulse; data inverted afterwards so stale values never match
    task push(input logic [20:0] v);
        @(posedge mclk);
        pushReq <= 1'b1;
        pushData <= v;
        @(posedge mclk);
        pushReq <= 1'b0;
        pushData <= ~v;
    endtask
    // one-cycle pop pulse, answer looked at in the cycle it stands
    task pop(output logic [20:0] d, output logic ok);
        @(posedge mclk);
        popReq <= 1'b1;
        @(posedge mclk);
        popReq <= 1'b0;
        #1;
        d = popData;
        ok = popValid;
    endtask
endmodule // rsc_core_model
`default_nettype wire

//--- rsc_top_tb.sv
// bench for the return stack and reset cause block
`timescale 1ns/1ns
`default_nettype none
`include "rsc_map.vh"
module rsc_top_tb;
    logic mclk, rst_b, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rv;
    logic [3:0] wstrb;
    wire awready, wready, bvalid, arready, rvalid, popValid, pcLoad, stackResetReq, pushReq, popReq;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [20:0] pushData, popData, pcLoadAddr;
    logic [20:0] pcNow, pd;
    logic [4:0] ev;
    wire evtBrownout = ev[0];
    wire evtExtClear = ev[1];
    wire evtWatchdog = ev[2];
    wire evtResetInstr = ev[3];
    wire evtIntWake = ev[4];
    logic wakeHighPri, overflowResetEnable, highPriorityGlobalEnable, lowPriorityGlobalEnable, ok;
    logic [1:0] pwrMode, brownoutConfigField, rr;
    logic [20:0] q [$];
    // event, power mode, expected reset cause after it
    logic [14:0] tbl [0:8] = '{15'h1054, 15'h095C, 15'h0A58, 15'h045C, 15'h204C, 15'h045C,
        15'h1350, 15'h045C, 15'h4258};
    integer err_count = 0, n_checks = 0, cyc = 0, seed = 41622, i, r;

    rsc_top i_rsc_top(.mclk, .rst_b, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
        .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
        .pushReq, .pushData, .popReq, .pcNow, .popData, .popValid, .evtResetInstr, .evtBrownout,
        .evtExtClear, .evtWatchdog, .evtIntWake, .wakeHighPri, .pwrMode, .overflowResetEnable,
        .brownoutConfigField, .highPriorityGlobalEnable, .lowPriorityGlobalEnable, .pcLoad,
        .pcLoadAddr, .stackResetReq);
    rsc_core_model i_rsc_core_model(.mclk, .pushReq, .pushData, .popReq, .popValid, .popData);

    // ==========================================================================
    // expectations
    function automatic [31:0] spv(input logic f, input logic u, input logic [4:0] s);
        spv = {24'h0, f, u, 1'b0, s};
    endfunction
    function automatic [31:0] tosb(input logic [20:0] v, input integer k);
        tosb = {24'h0, 8'(v >> (8 * k))};
    endfunction
    // ==========================================================================
    // comparison and verdict
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ==========================================================================
    // axi4-lite master
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (awvalid | wvalid);
        while (!bvalid) @(posedge mclk);
        rr = bresp;
        bready <= 1'b0;
    endtask
    task rc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge mclk); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge mclk);
        rv = rdata;
        rr = rresp;
        rready <= 1'b0;
        chk(nm, rv, exp);
    endtask
    task rp(input logic [31:0] exp);
        rc("pointer", `RSC_OFS_STACK_PTR, exp);
    endtask
    task evt(input logic [4:0] e, input logic [1:0] m);
        @(posedge mclk);
        r = $random(seed);
        ev <= e;
        pwrMode <= m;
        pcNow <= r[20:0];
        @(posedge mclk);
        ev <= 5'h00;
    endtask

    // clock and hang guard
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            summarize;
        end
    end

    initial begin
        {awvalid, wvalid, bready, arvalid, rready, overflowResetEnable, lowPriorityGlobalEnable} = 7'h00;
        {awaddr, araddr, wdata, pcNow, ev, pwrMode} = 0;
        wstrb = 4'hF;
        wakeHighPri = 1'b1;
        highPriorityGlobalEnable = 1'b1;
        brownoutConfigField = `RSC_BOR_CFG_SOFT;
        rst_b = 1'b0;
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        // power-on values
        rp(spv(0, 0, 0));
        rc("cause", `RSC_OFS_RESET_CAUSE, 32'h5C);
        $display("test reset done");
        // pushes, top entry, pops
        for (i = 0; i < 4; i++) begin
            r = $random(seed);
            i_rsc_core_model.push(r[20:0]);
            q.push_back(r[20:0]);
        end
        rp(spv(0, 0, 4));
        rc("tos low", `RSC_OFS_TOS_LOW, tosb(q[3], 0));
        rc("tos high", `RSC_OFS_TOS_HIGH, tosb(q[3], 1));
        rc("tos upper", `RSC_OFS_TOS_UPPER, tosb(q[3], 2));
        wr(`RSC_OFS_TOS_LOW, 32'hA5);
        q[3][7:0] = 8'hA5;
        for (i = 3; i >= 0; i--) begin
            i_rsc_core_model.pop(pd, ok);
            chk("pop data", 32'(pd), 32'(q[i]));
            chk("pop valid", 32'(ok), 1);
        end
        i_rsc_core_model.pop(pd, ok);
        chk("underflow data", 32'(pd), 0);
        rp(spv(0, 1, 0));
        evt(5'h01, `RSC_MODE_FULL);
        rp(spv(0, 1, 0));
        wr(`RSC_OFS_STACK_PTR, 32'h25);
        rp(spv(0, 0, 5));
        i_rsc_core_model.push(21'h012345);
        rp(spv(0, 0, 6));
        $display("test push pop done");
        // fill, then one push too many
        wr(`RSC_OFS_STACK_PTR, 32'h00);
        for (i = 0; i < 31; i++) i_rsc_core_model.push(21'(i));
        rp(spv(1, 0, 31));
        i_rsc_core_model.push(21'h1ABCD5);
        rp(spv(1, 0, 31));
        rc("tos low", `RSC_OFS_TOS_LOW, 32'h1E);
        evt(5'h02, `RSC_MODE_FULL);
        rp(spv(1, 0, 0));
        rc("cause", `RSC_OFS_RESET_CAUSE, 32'h5C);
        overflowResetEnable <= 1'b1;
        wr(`RSC_OFS_STACK_PTR, 32'h1E);
        i_rsc_core_model.push(21'h000777);
        rp(spv(1, 0, 0));
        $display("test overflow done");
        // each reset and wake kind in turn
        for (i = 0; i < 9; i++) begin
            evt(tbl[i][14:10], tbl[i][9:8]);
            #1;
            if (tbl[i][14]) chk("vector", 32'(pcLoadAddr), 32'(`RSC_VEC_HIGH));
            rc("cause", `RSC_OFS_RESET_CAUSE, 32'(tbl[i][7:0]));
        end
        brownoutConfigField <= 2'h0;
        evt(5'h01, `RSC_MODE_FULL);
        brownoutConfigField <= `RSC_BOR_CFG_SOFT;
        rc("cause", `RSC_OFS_RESET_CAUSE, 32'h1C);
        $display("test events done");
        // unmapped place
        rc("unmapped", 8'h14, 32'h0);
        chk("read resp", 32'(rr), 32'(`RSC_RESP_SLVERR));
        wr(8'h14, 32'hFF);
        chk("write resp", 32'(rr), 32'(`RSC_RESP_SLVERR));
        $display("test unmapped done");
        summarize;
    end
endmodule // rsc_top_tb
`default_nettype wire
